// >>> rtl/instr_fields_regs.vh
// Field positions, format codes and addressing-mode codes for the decoder
`ifndef INSTR_FIELDS_REGS_VH
`define INSTR_FIELDS_REGS_VH

// Field positions inside the halfword
`define TOP_HI          15
`define TOP_LO          12
`define FLD_A_HI        11
`define FLD_A_LO        8
`define FLD_B_HI        7
`define FLD_B_LO        4
`define FLD_C_HI        3
`define FLD_C_LO        0

// Format classes (4-bit code)
`define FMT_ZERO        4'h0
`define FMT_N           4'h1
`define FMT_M           4'h2
`define FMT_NM          4'h3
`define FMT_MD          4'h4
`define FMT_ND4         4'h5
`define FMT_NMD         4'h6
`define FMT_D8          4'h7
`define FMT_D12         4'h8
`define FMT_ND8         4'h9
`define FMT_I           4'hA
`define FMT_NI          4'hB

// Operand addressing modes (3-bit code)
`define AM_NONE         3'h0
`define AM_DIRECT       3'h1
`define AM_POSTINC      3'h2
`define AM_PREDEC       3'h3
`define AM_INDEXED      3'h4
`define AM_DISP         3'h5
`define AM_PCREL        3'h6
`define AM_GBR_INDEXED  3'h7

// Special operand targets (3-bit code)
`define SP_NONE         3'h0
`define SP_GP_ZERO      3'h1
`define SP_CTRL_SYS     3'h2
`define SP_ACCUM        3'h3

// No-operation code, the reset value of the opcode mask, and the trap vector shift
`define RST_INSTR       16'h0009
`define RST_MASK        16'hFFFF
`define TRAP_SHIFT      2

`endif

// >>> rtl/imm_extender.v
// Immediate extender: zero, sign or zero-then-times-four
`timescale 1ns/1ns
`default_nettype none
module imm_extender
(
  // Raw field
  input  wire [7:0]  imm_raw,
  // Extension choice
  input  wire        sign_ext,
  input  wire        scale4,
  // Result
  output wire [31:0] imm_ext
);
  // Sign copy of the top bit, only when asked
  wire [23:0] upper;
  assign upper = sign_ext ? {24{imm_raw[7]}} : 24'h00_0000;

  // Scaling is a plain shift of the zero-extended byte
  assign imm_ext = scale4 ? ({24'h00_0000, imm_raw} << 2)
                          : {upper, imm_raw};
endmodule
`default_nettype wire

// >>> rtl/instr_format_field_decoder.v
// Field extraction front end for 16-bit fixed-length instructions
`timescale 1ns/1ns
`default_nettype none
`include "instr_fields_regs.vh"
module instr_format_field_decoder
(
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // From fetch
  input  wire        fetch_valid,
  input  wire [15:0] fetch_instr,
  // Decoded fields
  output reg         dec_valid_ff,
  output reg  [3:0]  dec_format_ff,
  output reg  [15:0] dec_opcode_mask_ff,
  output reg  [3:0]  src_idx_ff,
  output reg  [3:0]  dst_idx_ff,
  output reg  [2:0]  src_mode_ff,
  output reg  [2:0]  dst_mode_ff,
  output reg  [2:0]  src_special_ff,
  output reg  [2:0]  dst_special_ff,
  output reg  [11:0] disp_ff,
  output reg         disp_valid_ff,
  output reg  [31:0] imm_ff,
  output reg         imm_valid_ff,
  output reg         src_post_inc_ff,
  output reg         dst_post_inc_ff
);
  // Field slices
  wire [3:0] top;
  wire [3:0] fa;
  wire [3:0] fb;
  wire [3:0] fc;
  wire [7:0] lo8;
  assign top = fetch_instr[`TOP_HI:`TOP_LO];
  assign fa  = fetch_instr[`FLD_A_HI:`FLD_A_LO];
  assign fb  = fetch_instr[`FLD_B_HI:`FLD_B_LO];
  assign fc  = fetch_instr[`FLD_C_HI:`FLD_C_LO];
  assign lo8 = fetch_instr[7:0];

  // Next values
  reg [3:0]  nxt_format;
  reg [15:0] nxt_mask;
  reg [3:0]  nxt_src;
  reg [3:0]  nxt_dst;
  reg [2:0]  nxt_smode;
  reg [2:0]  nxt_dmode;
  reg [2:0]  nxt_sspec;
  reg [2:0]  nxt_dspec;
  reg [11:0] nxt_disp;
  reg        nxt_dvalid;
  reg        nxt_ivalid;
  reg        nxt_sinc;
  reg        nxt_dinc;
  reg        sext;           // Immediate sign-extension select
  reg        trap4;          // Trap vector scaling select
  wire [31:0] imm_ext;       // Extended immediate

  // Shared extender for every 8-bit immediate
  imm_extender u_ext
  (
    .imm_raw  (lo8),
    .sign_ext (sext),
    .scale4   (trap4),
    .imm_ext  (imm_ext)
  );

  // Classify by the code bits, then slice the operand fields.
  // Only the classes this front end knows are listed; any other code
  // falls to the operand-free class so the datapath never sees junk.
  always @*
  begin
    nxt_format = `FMT_ZERO;
    nxt_mask   = 16'hFFFF;
    nxt_src    = 4'h0;
    nxt_dst    = 4'h0;
    nxt_smode  = `AM_NONE;
    nxt_dmode  = `AM_NONE;
    nxt_sspec  = `SP_NONE;
    nxt_dspec  = `SP_NONE;
    nxt_disp   = 12'h000;
    nxt_dvalid = 1'b0;
    nxt_ivalid = 1'b0;
    nxt_sinc   = 1'b0;
    nxt_dinc   = 1'b0;
    sext       = 1'b0;
    trap4      = 1'b0;
    case (top)
      4'h0:
      begin
        if (fetch_instr == `RST_INSTR)
        begin
          // No-operation: all code, no operands
          nxt_format = `FMT_ZERO;
        end
        else if (fc == 4'hF)
        begin
          // Multiply-accumulate word
          nxt_format = `FMT_NM;
          nxt_mask   = 16'hF00F;
          nxt_src    = fb;
          nxt_dst    = fa;
          nxt_smode  = `AM_POSTINC;
          nxt_dmode  = `AM_POSTINC;
          nxt_sinc   = 1'b1;
          nxt_dinc   = 1'b1;
          nxt_dspec  = `SP_ACCUM;
        end
        else if (fc == 4'h4 || fc == 4'h5 || fc == 4'h6)
        begin
          // Store to gp_reg_zero plus destination index
          nxt_format = `FMT_NM;
          nxt_mask   = 16'hF00F;
          nxt_src    = fb;
          nxt_dst    = fa;
          nxt_smode  = `AM_DIRECT;
          nxt_dmode  = `AM_INDEXED;
        end
        else if (fc == 4'hE && fb[3:2] == 2'b00)
        begin
          // Control register loaded from source
          nxt_format = `FMT_M;
          nxt_mask   = 16'hF0FF;
          nxt_src    = fa;
          nxt_smode  = `AM_DIRECT;
          nxt_dspec  = `SP_CTRL_SYS;
        end
        else
        begin
          nxt_format = `FMT_ZERO;
        end
      end
      4'h4:
      begin
        if (fc == 4'h7 || fc == 4'hA || fc == 4'hE)
        begin
          // Control/system load, post-incremented when from memory
          nxt_format = `FMT_M;
          nxt_mask   = 16'hF0FF;
          nxt_src    = fa;
          nxt_dspec  = `SP_CTRL_SYS;
          if (fc == 4'h7)
          begin
            nxt_smode = `AM_POSTINC;
            nxt_sinc  = 1'b1;
          end
          else
          begin
            nxt_smode = `AM_DIRECT;
          end
        end
      end
      4'h2, 4'h3, 4'h6:
      begin
        // Register-register: direct, indexed, post-inc or pre-dec
        nxt_format = `FMT_NM;
        nxt_mask   = 16'hF00F;
        nxt_src    = fb;
        nxt_dst    = fa;
        nxt_smode  = `AM_DIRECT;
        nxt_dmode  = `AM_DIRECT;
        if (top == 4'h2 && fc[3:2] == 2'b01)
        begin
          nxt_dmode = `AM_PREDEC;
        end
        else if (top == 4'h2 && fc[3:2] == 2'b00)
        begin
          nxt_dmode = `AM_INDEXED;
        end
        else if (top == 4'h6 && fc[3:2] == 2'b01)
        begin
          nxt_smode = `AM_POSTINC;
          nxt_sinc  = 1'b1;
        end
      end
      4'h1, 4'h5:
      begin
        // Displacement with two indices, store (1) or load (5)
        nxt_format = `FMT_NMD;
        nxt_mask   = 16'hF000;
        nxt_src    = fb;
        nxt_dst    = fa;
        nxt_disp   = {8'h00, fc};
        nxt_dvalid = 1'b1;
        nxt_smode  = (top == 4'h5) ? `AM_DISP : `AM_DIRECT;
        nxt_dmode  = (top == 4'h5) ? `AM_DIRECT : `AM_DISP;
      end
      4'h8:
      begin
        if (fa == 4'h4 || fa == 4'h5)
        begin
          // Load with displacement into gp_reg_zero
          nxt_format = `FMT_MD;
          nxt_mask   = 16'hFF00;
          nxt_src    = fb;
          nxt_smode  = `AM_DISP;
          nxt_disp   = {8'h00, fc};
          nxt_dvalid = 1'b1;
          nxt_dmode  = `AM_DIRECT;
          nxt_dspec  = `SP_GP_ZERO;
        end
        else if (fa == 4'h0 || fa == 4'h1)
        begin
          // Store with displacement from gp_reg_zero
          nxt_format = `FMT_ND4;
          nxt_mask   = 16'hFF00;
          nxt_dst    = fb;
          nxt_dmode  = `AM_DISP;
          nxt_disp   = {8'h00, fc};
          nxt_dvalid = 1'b1;
          nxt_smode  = `AM_DIRECT;
          nxt_sspec  = `SP_GP_ZERO;
        end
        else
        begin
          // Compare or conditional branch: short PC displacement
          nxt_format = `FMT_D8;
          nxt_mask   = 16'hFF00;
          nxt_disp   = {4'h0, lo8};
          nxt_dvalid = 1'b1;
          nxt_dmode  = `AM_PCREL;
        end
      end
      4'hA, 4'hB:
      begin
        // Long branch, no register operand
        nxt_format = `FMT_D12;
        nxt_mask   = 16'hF000;
        nxt_disp   = fetch_instr[11:0];
        nxt_dvalid = 1'b1;
        nxt_dmode  = `AM_PCREL;
      end
      4'h9, 4'hD:
      begin
        // PC-relative load into a register
        nxt_format = `FMT_ND8;
        nxt_mask   = 16'hF000;
        nxt_dst    = fa;
        nxt_dmode  = `AM_DIRECT;
        nxt_smode  = `AM_PCREL;
        nxt_disp   = {4'h0, lo8};
        nxt_dvalid = 1'b1;
      end
      4'hC:
      begin
        // Immediate-only class
        nxt_format = `FMT_I;
        nxt_mask   = 16'hFF00;
        nxt_ivalid = 1'b1;
        if (fa == 4'h3)
        begin
          trap4 = 1'b1;
        end
        else if (fa[3:2] == 2'b11)
        begin
          nxt_dmode = `AM_GBR_INDEXED;
        end
        else if (fa[3:2] == 2'b10)
        begin
          // Logic on gp_reg_zero, zero-extended
          nxt_dmode = `AM_DIRECT;
          nxt_dspec = `SP_GP_ZERO;
        end
        else
        begin
          nxt_dmode = `AM_DIRECT;
          nxt_dspec = `SP_GP_ZERO;
        end
      end
      4'h7, 4'hE:
      begin
        // Register plus sign-extended immediate
        nxt_format = `FMT_NI;
        nxt_mask   = 16'hF000;
        nxt_dst    = fa;
        nxt_dmode  = `AM_DIRECT;
        nxt_ivalid = 1'b1;
        sext       = 1'b1;
      end
      default:
      begin
        nxt_format = `FMT_ZERO;
      end
    endcase
    // Compare-equal immediate in the 8 group sign-extends too
    if (top == 4'h8 && fa == 4'h8)
    begin
      nxt_ivalid = 1'b1;
      nxt_dvalid = 1'b0;
      nxt_dmode  = `AM_NONE;
      nxt_sspec  = `SP_GP_ZERO;
      sext       = 1'b1;
    end
  end

  // Output stage; one cycle of latency keeps data outputs registered
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dec_valid_ff       <= 1'b0;
      dec_format_ff      <= `FMT_ZERO;
      dec_opcode_mask_ff <= `RST_MASK;
      src_idx_ff         <= 4'h0;
      dst_idx_ff         <= 4'h0;
      src_mode_ff        <= `AM_NONE;
      dst_mode_ff        <= `AM_NONE;
      src_special_ff     <= `SP_NONE;
      dst_special_ff     <= `SP_NONE;
      disp_ff            <= 12'h000;
      disp_valid_ff      <= 1'b0;
      imm_ff             <= 32'h0000_0000;
      imm_valid_ff       <= 1'b0;
      src_post_inc_ff    <= 1'b0;
      dst_post_inc_ff    <= 1'b0;
    end
    else
    begin
      dec_valid_ff       <= fetch_valid;
      dec_format_ff      <= nxt_format;
      dec_opcode_mask_ff <= nxt_mask;
      src_idx_ff         <= nxt_src;
      dst_idx_ff         <= nxt_dst;
      src_mode_ff        <= nxt_smode;
      dst_mode_ff        <= nxt_dmode;
      src_special_ff     <= nxt_sspec;
      dst_special_ff     <= nxt_dspec;
      disp_ff            <= nxt_disp;
      disp_valid_ff      <= nxt_dvalid;
      imm_ff             <= nxt_ivalid ? imm_ext : 32'h0000_0000;
      imm_valid_ff       <= nxt_ivalid;
      src_post_inc_ff    <= nxt_sinc;
      dst_post_inc_ff    <= nxt_dinc;
    end
  end
endmodule
`default_nettype wire

// >>> tb/fetch_model.sv
// Fetch stage model that hands one halfword per cycle to the decoder
`timescale 1ns/1ns
`default_nettype none
module fetch_model
(
  // Clock
  input  wire logic   clk,
  // Halfword to the decoder
  output logic        fetch_valid,
  output logic [15:0] fetch_instr
);
  // Start idle with a defined bus
  initial
  begin
    fetch_valid = 1'b0;
    fetch_instr = 16'h0000;
  end

  // Drive off the sampling edge and hold through one rising edge;
  // an empty slot shows the inverse bus so stale data never looks valid
  task automatic send(input logic [15:0] ins, input logic vld);
    @(negedge clk);
    fetch_valid = vld;
    fetch_instr = vld ? ins : ~fetch_instr;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> tb/instr_format_field_decoder_props.sv
// Checker for the decoded fields, one cycle after each sampled halfword
`timescale 1ns/1ns
`default_nettype none
`include "instr_fields_regs.vh"
module fmt_dec_props
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Fetch side
  input  wire logic [15:0] fetch_instr,
  // Decoded fields
  input  wire logic [3:0]  dec_format_ff,
  input  wire logic [15:0] dec_opcode_mask_ff,
  input  wire logic [3:0]  src_idx_ff,
  input  wire logic [3:0]  dst_idx_ff,
  input  wire logic [2:0]  dst_special_ff,
  input  wire logic [11:0] disp_ff,
  input  wire logic        disp_valid_ff,
  input  wire logic [31:0] imm_ff,
  input  wire logic        imm_valid_ff,
  input  wire logic        src_post_inc_ff,
  input  wire logic        dst_post_inc_ff
);
  logic [15:0] prev_ff;  // Halfword sampled at the last edge
  logic        armed_ff; // Low until one edge has passed out of reset

  // Reset outputs must not be judged against a pre-reset halfword
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prev_ff  <= 16'h0000;
      armed_ff <= 1'b0;
    end
    else
    begin
      prev_ff  <= fetch_instr;
      armed_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_NM_IDX: assert property (armed_ff && prev_ff[15:12] == 4'h3 &&
    prev_ff[3:0] == 4'hC |-> dec_format_ff == `FMT_NM &&
    dst_idx_ff == prev_ff[11:8] && src_idx_ff == prev_ff[7:4])
    else $error("two-register fields wrong");
  AST_MAC: assert property (armed_ff && prev_ff[15:12] == 4'h0 &&
    prev_ff[3:0] == 4'hF |-> dst_special_ff == `SP_ACCUM &&
    src_post_inc_ff && dst_post_inc_ff)
    else $error("multiply-accumulate operands wrong");
  AST_LD_DISP: assert property (armed_ff && prev_ff[15:8] == 8'h84
    |-> src_idx_ff == prev_ff[7:4] && disp_ff == {8'h00, prev_ff[3:0]}
    && dst_special_ff == `SP_GP_ZERO)
    else $error("load displacement fields wrong");
  AST_LONG_BR: assert property (armed_ff && prev_ff[15:12] == 4'hA
    |-> disp_valid_ff && disp_ff == prev_ff[11:0] && !imm_valid_ff)
    else $error("long branch displacement wrong");
  AST_PC_LOAD: assert property (armed_ff && prev_ff[15:12] == 4'h9
    |-> dst_idx_ff == prev_ff[11:8] && disp_ff == {4'h0, prev_ff[7:0]})
    else $error("pc load fields wrong");
  AST_NI_IMM: assert property (armed_ff && prev_ff[15:12] == 4'h7
    |-> dst_idx_ff == prev_ff[11:8] &&
    imm_ff == {{24{prev_ff[7]}}, prev_ff[7:0]})
    else $error("register immediate wrong");
  AST_TRAP: assert property (armed_ff && prev_ff[15:8] == 8'hC3
    |-> imm_valid_ff && imm_ff == ({24'h00_0000, prev_ff[7:0]} << 2))
    else $error("trap vector offset wrong");
  AST_LOGIC_ZX: assert property (armed_ff &&
    prev_ff[15:10] == 6'b110010 |-> imm_ff == {24'h00_0000, prev_ff[7:0]})
    else $error("logic immediate not zero extended");
  AST_NOP: assert property (armed_ff && prev_ff == 16'h0009
    |-> dec_format_ff == `FMT_ZERO && !disp_valid_ff && !imm_valid_ff &&
    dec_opcode_mask_ff == 16'hFFFF)
    else $error("all-opcode halfword shows operands");
endmodule
bind instr_format_field_decoder fmt_dec_props u_props
(
  .clk, .rst, .fetch_instr, .dec_format_ff, .dec_opcode_mask_ff,
  .src_idx_ff, .dst_idx_ff, .dst_special_ff, .disp_ff, .disp_valid_ff,
  .imm_ff, .imm_valid_ff, .src_post_inc_ff, .dst_post_inc_ff
);
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the instruction field decoder
`timescale 1ns/1ns
`default_nettype none
`include "instr_fields_regs.vh"
module tb_top;
  logic        clk = 1'b0;  // 20 MHz core clock
  logic        rst = 1'b1;  // Async reset, active high
  wire         fetch_valid;
  wire  [15:0] fetch_instr;
  wire         dec_valid_ff;
  wire  [3:0]  dec_format_ff;
  wire  [15:0] dec_opcode_mask_ff;
  wire  [3:0]  src_idx_ff;
  wire  [3:0]  dst_idx_ff;
  wire  [2:0]  src_mode_ff;
  wire  [2:0]  dst_mode_ff;
  wire  [2:0]  src_special_ff;
  wire  [2:0]  dst_special_ff;
  wire  [11:0] disp_ff;
  wire         disp_valid_ff;
  wire  [31:0] imm_ff;
  wire         imm_valid_ff;
  wire         src_post_inc_ff;
  wire         dst_post_inc_ff;
  int          bad_count = 0; // Mismatches
  int          checks = 0;    // Comparisons made

  // Clock, 50 ns period
  always #25 clk = ~clk;

  fetch_model u_fetch (.clk, .fetch_valid, .fetch_instr);
  instr_format_field_decoder u_dut
  (
    .clk, .rst, .fetch_valid, .fetch_instr, .dec_valid_ff, .dec_format_ff,
    .dec_opcode_mask_ff, .src_idx_ff, .dst_idx_ff, .src_mode_ff,
    .dst_mode_ff, .src_special_ff, .dst_special_ff, .disp_ff,
    .disp_valid_ff, .imm_ff, .imm_valid_ff, .src_post_inc_ff,
    .dst_post_inc_ff
  );

  // One compare for every field value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Present a halfword and let the edge's updates settle
  task automatic put(input logic [15:0] ins);
    u_fetch.send(ins, 1'b1);
    #1;
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Two-register and control-register classes, back to back, direct, indexed, post-inc and pre-dec modes
  task automatic t_nm;
    put(16'h3A5C);
    chk(dec_valid_ff, 1'b1);
    chk(dst_idx_ff, 4'hA);
    chk(src_idx_ff, 4'h5);
    chk(dec_opcode_mask_ff, 16'hF00F);
    chk(dec_format_ff, `FMT_NM);
    put(16'h2B36);
    chk(dst_mode_ff, `AM_PREDEC);
    put(16'h2B31);
    chk(dst_mode_ff, `AM_INDEXED);
    put(16'h6B36);
    chk(src_mode_ff, `AM_POSTINC);
    put(16'h0B36);
    chk(dst_mode_ff, `AM_INDEXED);
    put(16'h0E7F);
    chk(dst_special_ff, `SP_ACCUM);
    chk({src_post_inc_ff, dst_post_inc_ff}, 2'b11);
    put(16'h4D07);
    chk(src_idx_ff, 4'hD);
    chk(dst_special_ff, `SP_CTRL_SYS);
    chk(src_post_inc_ff, 1'b1);
    put(16'h4D0E);
    chk(src_mode_ff, `AM_DIRECT);
    chk(src_post_inc_ff, 1'b0);
    put(16'h0C0E);
    chk(src_idx_ff, 4'hC);
    chk(dec_opcode_mask_ff, 16'hF0FF);
    $display("t_nm done");
  endtask

  // Displacement classes, both directions
  task automatic t_disp;
    put(16'h8467);
    chk(src_idx_ff, 4'h6);
    chk(disp_ff, 12'h007);
    chk(dec_format_ff, `FMT_MD);
    put(16'h8945);
    chk(dst_mode_ff, `AM_PCREL);
    chk(disp_ff, 12'h045);
    put(16'h809E);
    chk(dst_idx_ff, 4'h9);
    chk(disp_ff, 12'h00E);
    chk(src_special_ff, `SP_GP_ZERO);
    put(16'h5CA3);
    chk({dst_idx_ff, src_idx_ff}, 8'hCA);
    chk(src_mode_ff, `AM_DISP);
    put(16'h1CA3);
    chk(dst_mode_ff, `AM_DISP);
    put(16'hAF81);
    chk(disp_ff, 12'hF81);
    chk(dec_format_ff, `FMT_D12);
    chk(dst_idx_ff, 4'h0);
    put(16'h93C4);
    chk(src_mode_ff, `AM_PCREL);
    $display("t_disp done");
  endtask

  // Immediate classes and extension kinds, the no-operation and an unlisted code, then an empty slot
  task automatic t_imm;
    put(16'h74F0);
    chk(imm_ff, 32'hFFFF_FFF0);
    chk(dst_idx_ff, 4'h4);
    put(16'hC3FF);
    chk(imm_ff, 32'h0000_03FC);
    chk(dst_mode_ff, `AM_NONE);
    put(16'hC880);
    chk(imm_ff, 32'h0000_0080);
    put(16'h8880);
    chk(imm_ff, 32'hFFFF_FF80);
    put(16'hCB55);
    chk(dst_special_ff, `SP_GP_ZERO);
    put(16'hCF12);
    chk(dst_mode_ff, `AM_GBR_INDEXED);
    put(16'h0009);
    chk({imm_valid_ff, disp_valid_ff}, 2'b00);
    chk(dec_format_ff, `FMT_ZERO);
    put(16'hF123);
    chk(dec_opcode_mask_ff, 16'hFFFF);
    u_fetch.send(16'h0000, 1'b0);
    #1;
    chk(dec_valid_ff, 1'b0);
    $display("t_imm done");
  endtask

  // Reset in mid-run clears the outputs at once, then decoding resumes
  task automatic t_rst;
    put(16'h3A5C);
    @(negedge clk);
    rst = 1'b1;
    #1;
    chk(dec_valid_ff, 1'b0);
    chk(dec_format_ff, `FMT_ZERO);
    @(negedge clk);
    rst = 1'b0;
    put(16'h3A5C);
    chk(dec_format_ff, `FMT_NM);
    $display("t_rst done");
  endtask

  // Watchdog, far beyond the few dozen cycles the tests need
  initial
  begin
    #100000;
    bad_count++;
    close_out;
  end

  // Reset for five cycles, then the scenarios
  initial
  begin
    repeat (5) @(posedge clk);
    #1;
    chk(dec_valid_ff, 1'b0);
    chk(dec_opcode_mask_ff, 16'hFFFF);
    @(negedge clk);
    rst = 1'b0;
    t_nm;
    t_disp;
    t_imm;
    t_rst;
    close_out;
  end
endmodule
`default_nettype wire
